// ### rtl/reset_cause_pkg.sv
package reset_cause_pkg;
  // Cause bit positions in the reset cause register.
  localparam int CAUSE_W = 5;
  localparam int CAUSE_EXT = 0;
  localparam int CAUSE_POR = 1;
  localparam int CAUSE_BOR = 2;
  localparam int CAUSE_WDT = 3;
  localparam int CAUSE_SW = 4;
  localparam logic [4:0] CAUSE_RESET = 5'h00;
  // Peripheral soft reset registers.
  localparam int NUM_SRCR = 3;
  localparam int PERIPH_W = 32;
  localparam int DOMAINS = 2;
  // Synchroniser depth and release stretch.
  localparam int SYNC_STAGES = 3;
  localparam int RELEASE_CYCLES = 4;
  localparam logic [2:0] RELEASE_LAST = 3'h3;
  // Watchdog.
  localparam int WDT_W = 32;
  localparam logic [31:0] WDT_LOAD_RESET = 32'hFFFFFFFF;
  localparam logic [31:0] WDT_ZERO = 32'h00000000;
  // Regulator adjust: 0 is 2.50 V, signed steps of 50 mV, limited to +-5 steps.
  localparam int REGULATOR_VOLTAGE_ADJUST_W = 6;
  localparam logic signed [5:0] REGULATOR_VOLTAGE_ADJUST_MIN = -6'sd5;
  localparam logic signed [5:0] REGULATOR_VOLTAGE_ADJUST_MAX = 6'sd5;
  localparam logic [5:0] REGULATOR_VOLTAGE_ADJUST_RESET = 6'h00;
  // Identification values, arbitrary.
  localparam int ID_REGS = 7;
  localparam logic [31:0] ID_DEFAULT = 32'h00010000;

  typedef enum logic [1:0] {RST_HOLD, RST_SYNC, RST_RUN} rst_state_e;

  typedef struct packed {
    logic ext;
    logic por;
    logic bor;
    logic wdt;
    logic sw;
  } src_s;

  typedef struct packed {
    logic coreRst;
    logic periphRst;
    logic tapRst;
  } rst_out_s;
endpackage

// ### rtl/ident_rom.sv
`timescale 1ns/1ps
// Read-only identification registers, read data registered.
module ident_rom #(
  parameter logic [32*7-1:0] ID_VALUES = {7{32'h00010000}}
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Read port.
  input wire logic [2:0] rdIdx,
  output logic [31:0] rdData
);
  import reset_cause_pkg::*;

  logic [31:0] rdData_d;

  // Index out of range reads zero rather than aliasing.
  always_comb begin
    rdData_d = 32'h00000000;
    if (int'(rdIdx) < ID_REGS) begin
      rdData_d = ID_VALUES[rdIdx*32 +: 32];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 32'h00000000;
    end else begin
      rdData <= rdData_d;
    end
  end
endmodule

// ### rtl/reset_cause_control.sv
`timescale 1ns/1ps
// Function
// - Five sources combine into internal reset: pin, POR, brown-out, software, watchdog.
// - Cause bit set per reset source; set bits stay across later resets other than power-on.
// - Power-on reset clears all other cause bits, leaving only POR.
// - Pin reset resets core and peripherals but not the scan TAP.
// - Pin release is synchronised a few clocks before internal reset releases.
// - Power-up holds reset until later of pin and POR goes inactive.
// - Internal POR happens only on initial power-up.
// - Power-on reset also resets the scan TAP controller.
// - Brown-out reset disabled after reset; software may enable it.
// - Brown-out gives interrupt, or reset only when enable bit set.
// - Brown-out reset acts like pin reset, held while supply low.
// - Three soft reset registers; set then clear resets that peripheral.
// - Soft reset bit positions match clock gating bit positions.
// - Peripheral soft reset asserts resets of all its clock domains.
// - System reset request resets core and peripherals but not the scan TAP, then releases.
// - First watchdog time-out is interrupt only; second causes system reset.
// - After first time-out watchdog reloads 32-bit counter from load value.
// - Watchdog resets only at zero while interrupt uncleared and reset enabled.
// - Regulator adjust field selects 2.25 V to 2.75 V in small steps.
// - Seven read-only identification registers report version, sizes and features.
module reset_cause_control #(
  parameter int NSRCR = reset_cause_pkg::NUM_SRCR,
  parameter int PW = reset_cause_pkg::PERIPH_W,
  parameter int ND = reset_cause_pkg::DOMAINS,
  parameter logic [32*7-1:0] ID_VALUES = {7{reset_cause_pkg::ID_DEFAULT}}
) (
  // Clock and power-on reset from the supply monitor, active low.
  input wire logic clk,
  input wire logic nrst,
  // External reset pin, active low, asynchronous.
  input wire logic extRstN,
  // Brown-out detector and its control.
  input wire logic brownoutLow,
  input wire logic brownoutResetEnable,
  output logic brownoutIrq,
  // Software system reset request pulse.
  input wire logic systemResetRequest,
  // Reset cause register write (write one to clear) and read.
  input wire logic causeClrWe,
  input wire logic [reset_cause_pkg::CAUSE_W-1:0] causeClrData,
  output logic [reset_cause_pkg::CAUSE_W-1:0] resetCause,
  // Peripheral soft reset registers, same bit map as clock gating.
  input wire logic softRstWe,
  input wire logic [1:0] softRstSel,
  input wire logic [PW-1:0] softRstData,
  output logic [NSRCR*PW-1:0] softRstRegs,
  output logic [NSRCR*PW*ND-1:0] periphDomainRst,
  // Watchdog.
  input wire logic wdtEnable,
  input wire logic wdtResetEnable,
  input wire logic wdtLoadWe,
  input wire logic [reset_cause_pkg::WDT_W-1:0] watchdogLoadValue,
  input wire logic wdtIrqClr,
  output logic wdtIrq,
  output logic [reset_cause_pkg::WDT_W-1:0] wdtCount,
  // Regulator adjust.
  input wire logic vadjWe,
  input wire logic [reset_cause_pkg::REGULATOR_VOLTAGE_ADJUST_W-1:0] vadjData,
  output logic [reset_cause_pkg::REGULATOR_VOLTAGE_ADJUST_W-1:0] regulatorVoltageAdjust,
  // Identification read.
  input wire logic [2:0] idIdx,
  output logic [31:0] idData,
  // Reset outputs.
  output reset_cause_pkg::rst_out_s rstOut
);
  import reset_cause_pkg::*;

  // Asynchronous assertion, synchronised release of the external pin.
  logic [SYNC_STAGES-1:0] extSync;
  logic extAsyncN;
  logic extHeldN;
  assign extAsyncN = nrst & extRstN;
  always_ff @(posedge clk or negedge extAsyncN) begin
    if (!extAsyncN) begin
      extSync <= '0;
    end else begin
      extSync <= {extSync[SYNC_STAGES-2:0], 1'b1};
    end
  end
  assign extHeldN = extSync[SYNC_STAGES-1];

  typedef struct packed {
    rst_state_e st;
    logic [2:0] cnt;
    logic [CAUSE_W-1:0] cause;
    logic [CAUSE_W-1:0] pend;
    logic porSeen;
    logic [NSRCR*PW-1:0] srcr;
    logic [NSRCR*PW-1:0] pulse;
    logic [WDT_W-1:0] wcnt;
    logic [WDT_W-1:0] wload;
    logic wirq;
    logic wrst;
    logic [REGULATOR_VOLTAGE_ADJUST_W-1:0] regulator_voltage_adjust;
    logic borIrq;
  } state_s;

  state_s s_q, s_d;
  logic [CAUSE_W-1:0] srcVec;
  logic anySrc;

  // Live sources; the pin and POR come through the synchroniser.
  always_comb begin
    srcVec = '0;
    srcVec[CAUSE_EXT] = ~extRstN;
    srcVec[CAUSE_POR] = ~s_q.porSeen;
    srcVec[CAUSE_BOR] = brownoutLow & brownoutResetEnable;
    srcVec[CAUSE_WDT] = s_q.wrst;
    srcVec[CAUSE_SW] = systemResetRequest;
    anySrc = ~extHeldN | srcVec[CAUSE_BOR] | srcVec[CAUSE_WDT] | srcVec[CAUSE_SW];
  end

  always_comb begin
    s_d = s_q;
    s_d.pulse = '0;
    s_d.borIrq = brownoutLow & ~brownoutResetEnable;
    // Cause clear by software; a cause landing in the same cycle wins below.
    if (causeClrWe) begin
      s_d.cause = s_q.cause & ~causeClrData;
    end
    s_d.pend = s_q.pend | srcVec;
    case (s_q.st)
      RST_HOLD: begin
        s_d.cnt = '0;
        // Holding while any source, including a low supply with brown-out reset enabled, stays active.
        if (!anySrc) begin
          s_d.st = RST_SYNC;
        end
      end
      RST_SYNC: begin
        if (anySrc) begin
          s_d.st = RST_HOLD;
        end else if (s_q.cnt == RELEASE_LAST) begin
          s_d.st = RST_RUN;
          s_d.porSeen = 1'b1;
          if (s_q.pend[CAUSE_POR]) begin
            s_d.cause = '0;
            s_d.cause[CAUSE_POR] = 1'b1;
          end else begin
            s_d.cause = s_d.cause | s_q.pend;
          end
          s_d.pend = '0;
        end else begin
          s_d.cnt = s_q.cnt + 3'h1;
        end
      end
      RST_RUN: begin
        if (anySrc) begin
          s_d.st = RST_HOLD;
        end
      end
      default: s_d.st = RST_HOLD;
    endcase
    // Soft reset registers: a falling bit gives a one-cycle reset pulse.
    if (softRstWe && int'(softRstSel) < NSRCR && s_q.st == RST_RUN) begin
      s_d.srcr[softRstSel*PW +: PW] = softRstData;
      s_d.pulse[softRstSel*PW +: PW] = s_q.srcr[softRstSel*PW +: PW] & ~softRstData;
    end
    // Regulator adjust, writes outside the legal window are ignored.
    if (vadjWe && $signed(vadjData) >= REGULATOR_VOLTAGE_ADJUST_MIN && $signed(vadjData) <= REGULATOR_VOLTAGE_ADJUST_MAX) begin
      s_d.regulator_voltage_adjust = vadjData;
    end
    // Interrupt clear sits ahead of the counter, so a time-out in the same cycle wins.
    if (wdtIrqClr) begin
      s_d.wirq = 1'b0;
    end
    // Watchdog.
    if (wdtLoadWe) begin
      s_d.wload = watchdogLoadValue;
      s_d.wcnt = watchdogLoadValue;
    end else if (wdtEnable && s_q.st == RST_RUN) begin
      if (s_q.wcnt == WDT_ZERO) begin
        s_d.wcnt = s_q.wload;
        if (s_q.wirq && wdtResetEnable) begin
          s_d.wrst = 1'b1;
        end
        s_d.wirq = 1'b1;
      end else begin
        s_d.wcnt = s_q.wcnt - 32'h1;
      end
    end
    if (s_q.st == RST_HOLD && s_q.wrst) begin
      s_d.wrst = 1'b0;
      s_d.wirq = 1'b0;
      s_d.wcnt = s_q.wload;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{st: RST_HOLD, cnt: '0, cause: CAUSE_RESET, pend: '0, porSeen: 1'b0,
               srcr: '0, pulse: '0, wcnt: WDT_LOAD_RESET, wload: WDT_LOAD_RESET,
               wirq: 1'b0, wrst: 1'b0, regulator_voltage_adjust: REGULATOR_VOLTAGE_ADJUST_RESET, borIrq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Per-domain resets: every domain of a peripheral sees the same request.
  genvar gi;
  generate
    for (gi = 0; gi < NSRCR * PW; gi++) begin : g_dom
      assign periphDomainRst[gi*ND +: ND] = {ND{s_q.pulse[gi] | rstOut.periphRst}};
    end
  endgenerate

  // Core and peripherals share the system reset; the TAP only sees POR.
  assign rstOut.coreRst = ~extAsyncN | (s_q.st != RST_RUN);
  assign rstOut.periphRst = rstOut.coreRst;
  assign rstOut.tapRst = ~nrst | ~s_q.porSeen;
  assign resetCause = s_q.cause;
  assign softRstRegs = s_q.srcr;
  assign wdtIrq = s_q.wirq;
  assign wdtCount = s_q.wcnt;
  assign regulatorVoltageAdjust = s_q.regulator_voltage_adjust;
  assign brownoutIrq = s_q.borIrq;

  ident_rom #(.ID_VALUES(ID_VALUES)) u_id (
    .clk(clk),
    .nrst(nrst),
    .rdIdx(idIdx),
    .rdData(idData)
  );

  // Cause register: a power-on release wipes the others, every other cause only accumulates.
  a_por_only_cause: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.st == RST_SYNC && s_q.cnt == RELEASE_LAST && !anySrc && s_q.pend[CAUSE_POR])
    |=> resetCause == (CAUSE_W'(1) << CAUSE_POR))
    else $error("POR did not leave only POR cause");
  a_cause_sticky: assert property (@(posedge clk) disable iff (!nrst)
    (!causeClrWe && !s_q.pend[CAUSE_POR])
    |=> (resetCause & $past(resetCause)) == $past(resetCause))
    else $error("Cause bit lost");

  // Brown-out: an interrupt while the reset is disabled, a held reset once it is enabled.
  a_bor_disabled: assert property (@(posedge clk) disable iff (!nrst)
    (brownoutLow && !brownoutResetEnable) |=> brownoutIrq)
    else $error("Brown-out irq missing");
  a_bor_hold: assert property (@(posedge clk) disable iff (!nrst)
    (brownoutLow && brownoutResetEnable) |=> rstOut.coreRst)
    else $error("Brown-out reset dropped");

  // Release sequencing: the pin keeps the core held until it has crossed the synchroniser.
  a_sync_release: assert property (@(posedge clk) disable iff (!nrst)
    $rose(extRstN) |-> rstOut.coreRst [*3])
    else $error("Release not synchronised");
  a_pin_hold: assert property (@(posedge clk) disable iff (!nrst)
    !extHeldN |=> rstOut.coreRst)
    else $error("Internal reset released while pin still held");
  a_release_run: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.st == RST_SYNC && s_q.cnt == RELEASE_LAST && !anySrc) |=> s_q.st == RST_RUN)
    else $error("Release count did not end in run");

  // Power-on bookkeeping: only a supply ramp may clear the flag that spares the scan port.
  a_por_once: assert property (@(posedge clk) disable iff (!nrst)
    s_q.porSeen |=> s_q.porSeen)
    else $error("Power-on flag dropped without a supply ramp");
  a_tap_por: assert property (@(posedge clk) disable iff (!nrst)
    $fell(rstOut.tapRst) |-> $past(s_q.st) == RST_SYNC && s_q.st == RST_RUN)
    else $error("Scan controller left reset before the power-on release");
  a_tap_kept: assert property (@(posedge clk) disable iff (!nrst)
    (s_q.porSeen && !extRstN) |-> !rstOut.tapRst)
    else $error("Pin reset hit TAP");

  // Watchdog: first zero interrupts and reloads, a second unserviced zero resets.
  a_wdt_reload: assert property (@(posedge clk) disable iff (!nrst)
    (wdtEnable && !wdtLoadWe && s_q.st == RST_RUN && wdtCount == WDT_ZERO)
    |=> wdtCount == $past(s_q.wload) && wdtIrq)
    else $error("Watchdog reload wrong");
  a_wdt_first_irq: assert property (@(posedge clk) disable iff (!nrst)
    (wdtEnable && !wdtLoadWe && s_q.st == RST_RUN && wdtCount == WDT_ZERO && !wdtIrq
     && !s_q.wrst) |=> !s_q.wrst)
    else $error("First watchdog time-out caused a reset");
  a_wdt_reset: assert property (@(posedge clk) disable iff (!nrst)
    $rose(s_q.wrst) |-> $past(wdtIrq) && $past(wdtResetEnable) && $past(wdtCount) == WDT_ZERO)
    else $error("Bad wdt reset");
  a_irq_held: assert property (@(posedge clk) disable iff (!nrst)
    (wdtIrq && !wdtIrqClr && !(s_q.st == RST_HOLD && s_q.wrst)) |=> wdtIrq)
    else $error("Watchdog interrupt dropped without a clear");
  a_swreq_reset: assert property (@(posedge clk) disable iff (!nrst)
    systemResetRequest |=> rstOut.coreRst)
    else $error("Software reset missing");

  // Soft resets and regulator window.
  a_soft_pulse: assert property (@(posedge clk) disable iff (!nrst)
    (softRstWe && softRstSel == 2'h0 && s_q.st == RST_RUN && s_q.srcr[0] && !softRstData[0])
    |=> periphDomainRst[0] && periphDomainRst[ND-1])
    else $error("Soft reset pulse missing");
  a_soft_refused: assert property (@(posedge clk) disable iff (!nrst)
    (softRstWe && int'(softRstSel) >= NSRCR) |=> $stable(softRstRegs))
    else $error("Write to a missing soft reset register landed");
  a_regulator_voltage_adjust_window: assert property (@(posedge clk) disable iff (!nrst)
    $signed(regulatorVoltageAdjust) >= REGULATOR_VOLTAGE_ADJUST_MIN && $signed(regulatorVoltageAdjust) <= REGULATOR_VOLTAGE_ADJUST_MAX)
    else $error("Regulator adjust outside its window");

  // Main scenarios that a run should reach at least once.
  c_pin_reset: cover property (@(posedge clk) disable iff (!nrst) $rose(extRstN));
  c_wdt_second: cover property (@(posedge clk) disable iff (!nrst) $rose(s_q.wrst));
  c_bor_reset: cover property (@(posedge clk) disable iff (!nrst)
    brownoutLow && brownoutResetEnable);
  c_soft_periph: cover property (@(posedge clk) disable iff (!nrst) |s_q.pulse);
  c_irq_cleared: cover property (@(posedge clk) disable iff (!nrst) wdtIrq && wdtIrqClr);
endmodule

// ### testbench/reset_far_side.sv
`timescale 1ns/1ps
// Behavioural pin and supply monitor side of the reset block.
module reset_far_side (
  // Commands from the bench.
  input wire logic pinLow,
  input wire logic supplyDip,
  // Lines seen by the block.
  output logic extRstN,
  output logic brownoutLow
);
  // The pin has a pull-up, so a released pin reads high, never a stale level.
  assign extRstN = !pinLow;
  // The detector reports low supply for exactly as long as the dip lasts.
  assign brownoutLow = supplyDip;
endmodule

// ### testbench/reset_cause_control_bench.sv
`timescale 1ns/1ps
module reset_cause_control_bench;
  import reset_cause_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, pinLow = 1'b0, supplyDip = 1'b0, borEn = 1'b0, swReq = 1'b0;
  logic causeClrWe = 1'b0, softRstWe = 1'b0, wdtEnable = 1'b0, wdtResetEnable = 1'b0;
  logic wdtLoadWe = 1'b0, wdtIrqClr = 1'b0, vadjWe = 1'b0;
  logic [4:0] causeClrData = 5'h00;
  logic [1:0] softRstSel = 2'h0;
  logic [31:0] softRstData = 32'h0, watchdog_load_value = 32'h0, wdtCount, idData;
  logic [5:0] vadjData = 6'h00, regulator_voltage_adjust;
  logic [2:0] idIdx = 3'h0;
  logic extRstN, brownoutLow, brownoutIrq, wdtIrq;
  logic [4:0] resetCause;
  logic [95:0] softRstRegs;
  logic [191:0] periphDomainRst;
  rst_out_s rstOut;
  int err_total = 0;
  int n_checks = 0;
  int n;

  // Clock of 40 ns period.
  always #20 clk = ~clk;

  reset_far_side far (.pinLow(pinLow), .supplyDip(supplyDip), .extRstN(extRstN),
    .brownoutLow(brownoutLow));
  reset_cause_control uut (.clk(clk), .nrst(nrst), .extRstN(extRstN),
    .brownoutLow(brownoutLow), .brownoutResetEnable(borEn), .brownoutIrq(brownoutIrq),
    .systemResetRequest(swReq), .causeClrWe(causeClrWe), .causeClrData(causeClrData),
    .resetCause(resetCause), .softRstWe(softRstWe), .softRstSel(softRstSel),
    .softRstData(softRstData), .softRstRegs(softRstRegs), .periphDomainRst(periphDomainRst),
    .wdtEnable(wdtEnable), .wdtResetEnable(wdtResetEnable), .wdtLoadWe(wdtLoadWe),
    .watchdogLoadValue(watchdog_load_value), .wdtIrqClr(wdtIrqClr), .wdtIrq(wdtIrq), .wdtCount(wdtCount),
    .vadjWe(vadjWe), .vadjData(vadjData), .regulatorVoltageAdjust(regulator_voltage_adjust), .idIdx(idIdx),
    .idData(idData), .rstOut(rstOut));

  // Compare and count; four-state compare so an unknown never matches.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Inputs always move 1 ns after the rising edge.
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Bounded wait for the core to leave reset; returns the cycles taken.
  task wait_run(output int c);
    c = 0;
    while (rstOut.coreRst !== 1'b0 && c < 40) begin
      step(1);
      c++;
    end
    chk(rstOut.coreRst, 0);
  endtask

  task soft_wr(input logic [1:0] s, input logic [31:0] d);
    softRstSel = s;
    softRstData = d;
    softRstWe = 1'b1;
    step(1);
    softRstWe = 1'b0;
  endtask

  task end_of_test;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog sized well above the planned run of about 130 cycles.
  initial begin
    #200us;
    err_total++;
    end_of_test();
  end

  initial begin
    step(10);
    chk(rstOut.tapRst, 1);
    nrst = 1'b1;
    wait_run(n);
    chk(resetCause, 5'h02);
    chk(rstOut.tapRst, 0);
    $display("power-on done");
    // Pin reset asserts at once, spares the scan controller, releases after sync.
    pinLow = 1'b1;
    #1;
    chk(rstOut.coreRst, 1);
    chk(rstOut.periphRst, 1);
    chk(rstOut.tapRst, 0);
    step(3);
    pinLow = 1'b0;
    wait_run(n);
    chk(n >= SYNC_STAGES, 1);
    chk(resetCause, 5'h03);
    causeClrData = 5'h1F;
    causeClrWe = 1'b1;
    step(1);
    causeClrWe = 1'b0;
    step(1);
    chk(resetCause, 5'h00);
    $display("pin reset done");
    // Brown-out only interrupts while disabled, then holds reset while low.
    supplyDip = 1'b1;
    step(4);
    chk(rstOut.coreRst, 0);
    chk(brownoutIrq, 1);
    borEn = 1'b1;
    step(12);
    chk(rstOut.coreRst, 1);
    supplyDip = 1'b0;
    borEn = 1'b0;
    wait_run(n);
    chk(resetCause, 5'h04);
    $display("brown-out done");
    // Software system reset request.
    swReq = 1'b1;
    step(1);
    swReq = 1'b0;
    step(1);
    chk(rstOut.coreRst, 1);
    wait_run(n);
    chk(resetCause, 5'h14);
    $display("system request done");
    // Set then clear one peripheral bit; a refused select changes nothing.
    soft_wr(2'h1, 32'h20);
    chk(softRstRegs[63:32], 32'h20);
    step(1);
    soft_wr(2'h1, 32'h0);
    chk(periphDomainRst[74 +: 2], 2'h3);
    chk(periphDomainRst[10 +: 2], 2'h0);
    step(1);
    chk(periphDomainRst[74 +: 2], 2'h0);
    soft_wr(2'h3, 32'hFFFFFFFF);
    chk(softRstRegs[95:64] | softRstRegs[63:32] | softRstRegs[31:0], 32'h0);
    step(1);
    soft_wr(2'h0, 32'h1);
    step(1);
    soft_wr(2'h0, 32'h0);
    chk(periphDomainRst[1:0], 2'h3);
    $display("peripheral reset done");
    // Watchdog: first zero interrupts and reloads; after a clear the second zero interrupts again, the third resets.
    wdtResetEnable = 1'b1;
    watchdog_load_value = 32'h8;
    wdtLoadWe = 1'b1;
    step(1);
    wdtLoadWe = 1'b0;
    wdtEnable = 1'b1;
    n = 0;
    while (wdtIrq !== 1'b1 && n < 30) begin
      step(1);
      n++;
    end
    chk(wdtIrq, 1);
    chk(rstOut.coreRst, 0);
    chk(wdtCount <= 32'h8 && wdtCount >= 32'h6, 1);
    // A serviced first time-out must not reset; the next zero only interrupts again.
    wdtIrqClr = 1'b1;
    step(1);
    wdtIrqClr = 1'b0;
    chk(wdtIrq, 0);
    n = 0;
    while (wdtIrq !== 1'b1 && n < 30) begin
      step(1);
      n++;
    end
    chk(wdtIrq, 1);
    chk(rstOut.coreRst, 0);
    n = 0;
    while (rstOut.coreRst !== 1'b1 && n < 30) begin
      step(1);
      n++;
    end
    chk(rstOut.coreRst, 1);
    wdtEnable = 1'b0;
    wait_run(n);
    chk(resetCause[CAUSE_WDT], 1);
    $display("watchdog done");
    // Regulator steps: +5 and -5 accepted, +6 refused.
    vadjData = 6'h05;
    vadjWe = 1'b1;
    step(1);
    chk(regulator_voltage_adjust, 6'h05);
    vadjData = 6'h06;
    step(1);
    chk(regulator_voltage_adjust, 6'h05);
    vadjData = 6'h3B;
    step(1);
    vadjWe = 1'b0;
    chk(regulator_voltage_adjust, 6'h3B);
    idIdx = 3'h0;
    step(2);
    chk(idData, ID_DEFAULT);
    idIdx = 3'h7;
    step(2);
    chk(idData, 32'h0);
    $display("regulator and ident done");
    // Power-up with the pin held past the supply ramp: release waits for the pin.
    nrst = 1'b0;
    pinLow = 1'b1;
    step(2);
    chk(rstOut.tapRst, 1);
    nrst = 1'b1;
    step(12);
    chk(rstOut.coreRst, 1);
    chk(rstOut.tapRst, 1);
    pinLow = 1'b0;
    wait_run(n);
    chk(n >= SYNC_STAGES, 1);
    chk(resetCause, 5'h02);
    chk(rstOut.tapRst, 0);
    $display("power-up with pin held done");
    end_of_test();
  end
endmodule
